/* File: hw/ident_byte_sel.sv */
// Byte selector for the hard-wired identity values
`timescale 1ns/1ns
`default_nettype none
`include "pmbus_ident_consts.svh"

module ident_byte_sel #(
  parameter logic [15:0] WORD_VAL = 16'hA55A,          // Arbitrary value
  parameter logic [47:0] STR_VAL  = 48'h0123456789AB   // Arbitrary value
) (
  input  wire logic       is_string,
  input  wire logic [2:0] idx,
  output logic      [7:0] byte_out
);

  // Pick a byte; the string leads with its count as a block read does
  always_comb begin
    byte_out = `IDENT_PAD_BYTE;
    if (is_string) begin
      if (idx == 3'h0) begin
        // Block read count byte
        byte_out = {5'h00, `IDENT_STRING_BYTES};
      end else if (idx <= `IDENT_STRING_BYTES) begin
        // Least significant byte first
        byte_out = STR_VAL[(idx - 3'h1) * 8 +: 8];
      end
    end else if (idx < `IDENT_WORD_BYTES) begin
      // Word goes low byte first
      byte_out = WORD_VAL[idx * 8 +: 8];
    end
  end

endmodule
`default_nettype wire

/* File: hw/pmbus_ident_and_store_lock.sv */
// Identity commands and store-lock gate of the command engine
// How it works
// R1 - Lock clear: save command writable unless blocked
// R2 - Lock set: save command read-only from one cycle after the lock sets
// R3 - Word identity answered on read word
// R4 - Word write accepted, data dropped
// R5 - Writes never change identity readback
// R6 - Identity writes never raise comm fault
// R7 - Six-byte identity answered on block read
// R8 - Block write accepted, bytes dropped
// R9 - Identity not phased, stored or restored
// R10 - Identity values are hard-wired constants
`timescale 1ns/1ns
`default_nettype none
`include "pmbus_ident_consts.svh"

module pmbus_ident_and_store_lock
  import pmbus_ident_pkg::*;
#(
  parameter logic [15:0] IDENT_WORD   = 16'hA55A,        // Arbitrary value
  parameter logic [47:0] IDENT_STRING = 48'h0123456789AB // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       txn_start,
  input  wire logic [7:0] txn_cmd,
  input  wire logic       txn_write,
  input  wire logic       txn_end,
  input  wire logic       wr_byte_valid,
  input  wire logic [7:0] wr_byte,
  input  wire logic       rd_byte_req,
  input  wire logic       lock_wr_valid,
  input  wire logic       lock_wr_data,
  input  wire logic       restore,
  input  wire logic       nvm_store_lock,
  input  wire logic       wp_blocks_store,
  input  wire logic       key_blocks_store,
  output logic            cmd_ack,
  output logic      [7:0] rd_byte,
  output logic            rd_valid,
  output logic            store_lock_bit,
  output logic            store_cmd_writable,
  output logic            cml_fault
);

  import pmbus_ident_pkg::*;

  state_s      st;       // Registered state
  state_s      next_st;  // Next state
  logic [7:0]  sel_byte; // Byte at the current read position
  logic        our_cmd;  // Start names one of our commands
  logic        pick_str; // Start names the six-byte command

  // Constant lookup, no storage behind it
  ident_byte_sel #(
    .WORD_VAL (IDENT_WORD),
    .STR_VAL  (IDENT_STRING)
  ) u_sel (
    .is_string (st.is_string),
    .idx       (st.idx),
    .byte_out  (sel_byte)
  );

  // Command decode at the start of a transaction
  always_comb begin
    pick_str = (txn_cmd == `CMD_IDENT_STRING);
    our_cmd  = pick_str || (txn_cmd == `CMD_IDENT_WORD);
  end

  // Next-state logic
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    next_st.cmd_ack  = 1'b0;
    // Written bytes are never used, so no fault can arise from them
    next_st.cml_fault = 1'b0; // R6
    unique case (st.mode)
      MODE_IDLE: begin
        if (txn_start && our_cmd) begin
          next_st.is_string = pick_str;
          next_st.idx       = `IDX_RESET;
          // Writes get the same acceptance as reads
          next_st.cmd_ack   = 1'b1; // R4 R8
          next_st.mode      = txn_write ? MODE_WRITE : MODE_READ;
        end
      end
      MODE_READ: begin
        if (txn_end) begin
          next_st.mode = MODE_IDLE;
        end else if (rd_byte_req) begin
          // Hand out the constant byte and step on
          next_st.rd_byte  = sel_byte; // R3 R7 R10
          next_st.rd_valid = 1'b1;
          if (st.idx != 3'h7) begin
            next_st.idx = st.idx + 3'h1;
          end
        end
      end
      MODE_WRITE: begin
        // Data bytes are swallowed; nothing stores them
        if (txn_end) begin
          next_st.mode = MODE_IDLE; // R4 R5 R8
        end
      end
    endcase
    // Lock follows host writes, restore reloads from storage
    if (!st.loaded) begin
      next_st.store_lock = nvm_store_lock; // R2
      next_st.loaded     = 1'b1;
    end else if (restore) begin
      next_st.store_lock = nvm_store_lock; // R2
    end else if (lock_wr_valid) begin
      next_st.store_lock = lock_wr_data;
    end
    // Gate lags the lock by one cycle since it is registered; it stays shut
    // until the stored lock has loaded, so a set lock loaded at power-on never leaks a writable cycle
    next_st.writable = st.loaded && !st.store_lock && !wp_blocks_store
                       && !key_blocks_store; // R1 R2
  end

  // State register; of the identity values only the byte last read out enters it, in rd_byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.mode       <= MODE_IDLE;
      st.is_string  <= 1'b0;
      st.idx        <= `IDX_RESET;
      st.rd_byte    <= `BYTE_RESET;
      st.rd_valid   <= 1'b0;
      st.cmd_ack    <= 1'b0;
      st.store_lock <= `STORE_LOCK_RESET;
      st.loaded     <= 1'b0;
      st.writable   <= 1'b0;
      st.cml_fault  <= 1'b0;
    end else begin
      st <= next_st; // R9
    end
  end

  // Outputs straight from flops
  always_comb begin
    cmd_ack            = st.cmd_ack;
    rd_byte            = st.rd_byte;
    rd_valid           = st.rd_valid;
    store_lock_bit     = st.store_lock;
    store_cmd_writable = st.writable;
    cml_fault          = st.cml_fault;
  end

  // Unused write data is deliberately dropped
  logic wr_unused; // Keeps the sink visible
  always_comb begin
    wr_unused = wr_byte_valid ^ (^wr_byte);
  end

  // Checks on the driven outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LOCK_READONLY: assert property ( // R2
    st.loaded && st.store_lock |=> !store_cmd_writable)
    else $error("save command writable while locked");

  AST_UNLOCK_WRITABLE: assert property ( // R1
    st.loaded && !st.store_lock && !wp_blocks_store && !key_blocks_store
      |=> store_cmd_writable)
    else $error("save command not writable while unlocked");

  AST_WORD_LOW: assert property ( // R3
    st.mode == MODE_READ && !st.is_string && st.idx == 3'h0 && rd_byte_req && !txn_end
      |=> rd_valid && rd_byte == IDENT_WORD[7:0])
    else $error("wrong first byte of identity word");

  AST_WORD_HIGH: assert property ( // R3
    st.mode == MODE_READ && !st.is_string && st.idx == 3'h1 && rd_byte_req && !txn_end
      |=> rd_valid && rd_byte == IDENT_WORD[15:8])
    else $error("wrong second byte of identity word");

  AST_BLOCK_COUNT: assert property ( // R7
    st.mode == MODE_READ && st.is_string && st.idx == 3'h0 && rd_byte_req && !txn_end
      |=> rd_valid && rd_byte == 8'h06)
    else $error("block read count is not six");

  AST_BLOCK_LAST: assert property ( // R7
    st.mode == MODE_READ && st.is_string && st.idx == 3'h6 && rd_byte_req && !txn_end
      |=> rd_byte == IDENT_STRING[47:40])
    else $error("wrong last byte of identity string");

  AST_WRITE_ACK: assert property ( // R4
    st.mode == MODE_IDLE && txn_start && txn_write && txn_cmd == 8'hFC
      |=> cmd_ack ##1 !cmd_ack)
    else $error("word write not accepted");

  AST_BLOCK_WRITE_ACK: assert property ( // R8
    st.mode == MODE_IDLE && txn_start && txn_write && txn_cmd == 8'hFD
      |=> cmd_ack && st.mode == MODE_WRITE)
    else $error("block write not accepted");

  AST_WRITE_NO_CHANGE: assert property ( // R5
    st.mode == MODE_WRITE |=> $stable(rd_byte) && !rd_valid)
    else $error("readback changed during write");

  AST_NO_FAULT: assert property ( // R6
    st.mode == MODE_WRITE && wr_byte_valid |=> !cml_fault [*2])
    else $error("fault raised by identity write");

  AST_RESTORE_LOCK: assert property ( // R2
    st.loaded && restore && nvm_store_lock |=> store_lock_bit ##1 !store_cmd_writable)
    else $error("restore of set lock left save writable");

  AST_RESTORE_KEEPS_ID: assert property ( // R9
    restore && !(st.mode == MODE_READ && rd_byte_req) |=> $stable(rd_byte))
    else $error("restore disturbed identity readback");

  AST_POWERON_SHUT: assert property ( // R2
    !st.loaded |=> !store_cmd_writable)
    else $error("save command writable before lock loaded");

  AST_FOREIGN_NO_ACK: assert property ( // R3
    st.mode == MODE_IDLE && txn_start && txn_cmd != `CMD_IDENT_WORD
      && txn_cmd != `CMD_IDENT_STRING |=> !cmd_ack)
    else $error("foreign command acknowledged");

  AST_WORD_READ_ACK: assert property ( // R3
    st.mode == MODE_IDLE && txn_start && !txn_write && txn_cmd == `CMD_IDENT_WORD
      |=> cmd_ack && st.mode == MODE_READ)
    else $error("word read not accepted");

endmodule
`default_nettype wire

/* File: hw/pmbus_ident_consts.svh */
// Constants for the identity commands and store-lock logic
`ifndef PMBUS_IDENT_CONSTS_SVH
`define PMBUS_IDENT_CONSTS_SVH

// Command codes handled here
`define CMD_IDENT_WORD    8'hFC
`define CMD_IDENT_STRING  8'hFD

// Payload lengths in bytes
`define IDENT_WORD_BYTES    3'h2
`define IDENT_STRING_BYTES  3'h6

// Byte returned past the end of a payload
`define IDENT_PAD_BYTE      8'hFF

// Reset values of the held state
`define STORE_LOCK_RESET    1'b0
`define BYTE_RESET          8'h00
`define IDX_RESET           3'h0

`endif

/* File: hw/pmbus_ident_pkg.sv */
// Types shared by the identity command block
package pmbus_ident_pkg;

  // Transaction phase of the command slot
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_READ,
    MODE_WRITE
  } mode_e;

  // Whole state of the top module
  typedef struct packed {
    mode_e       mode;       // Current transaction phase
    logic        is_string;  // Selected command is the six-byte one
    logic [2:0]  idx;        // Next byte position on read
    logic [7:0]  rd_byte;    // Last byte handed out
    logic        rd_valid;   // One-cycle pulse with rd_byte
    logic        cmd_ack;    // One-cycle pulse, command accepted
    logic        store_lock; // Store-lock bit
    logic        loaded;     // Power-on load of the lock done
    logic        writable;   // Save-all-settings command writable
    logic        cml_fault;  // Communication fault flag
  } state_s;

endpackage

/* File: sim/pmbus_host_model.sv */
// Host controller model issuing identity command transactions
`timescale 1ns/1ns
`default_nettype none

module pmbus_host_model (
  input  wire logic       clk,
  input  wire logic       cmd_ack,
  input  wire logic [7:0] rd_byte,
  input  wire logic       rd_valid,
  output logic            txn_start,
  output logic      [7:0] txn_cmd,
  output logic            txn_write,
  output logic            txn_end,
  output logic            wr_byte_valid,
  output logic      [7:0] wr_byte,
  output logic            rd_byte_req
);
  // Quiet bus from time zero
  initial begin
    {txn_start, txn_cmd, txn_write, txn_end, wr_byte_valid, wr_byte, rd_byte_req} = '0;
  end

  // One whole transaction with n data cycles, back to back
  task automatic xfer(input logic [7:0] cmd, input logic wr, input int n,
                      output logic ack, output logic [7:0] q [8]);
    @(posedge clk);
    #5 txn_start = 1'b1;
    txn_cmd = cmd;
    txn_write = wr;
    @(posedge clk);
    #5 txn_start = 1'b0;
    ack = cmd_ack;
    // Read requests or write bytes, never a mixed kind
    rd_byte_req = !wr;
    wr_byte_valid = wr;
    for (int i = 0; i < n; i++) begin
      // Data pattern changes each byte; the block drops it and no check looks at it
      wr_byte = 8'hC3 ^ 8'(i);
      @(posedge clk);
      // A missing strobe turns the byte unknown so it cannot match
      #5 q[i] = (wr || rd_valid === 1'b1) ? rd_byte : 8'hXX;
    end
    txn_end = 1'b1;
    rd_byte_req = 1'b0;
    wr_byte_valid = 1'b0;
    @(posedge clk);
    #5 txn_end = 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: sim/pmbus_ident_and_store_lock_test.sv */
// Testbench for identity commands and store-lock gate
`timescale 1ns/1ns
`default_nettype none
`include "pmbus_ident_consts.svh"

module pmbus_ident_and_store_lock_test;
  localparam logic [15:0] WORD = 16'h1234;         // Arbitrary value
  localparam logic [47:0] STR  = 48'h0A1B2C3D4E5F; // Arbitrary value
  logic       clk, rst_n, txn_start, txn_write, txn_end, wr_byte_valid, rd_byte_req;
  logic       lock_wr_valid, lock_wr_data, restore, nvm_store_lock, wp, key;
  logic       cmd_ack, rd_valid, store_lock_bit, store_cmd_writable, cml_fault, ack;
  logic [7:0] txn_cmd, wr_byte, rd_byte;
  logic [7:0] q [8];        // Bytes of the last transaction
  int         errors, comparisons, cycles;

  pmbus_ident_and_store_lock #(.IDENT_WORD(WORD), .IDENT_STRING(STR))
    u_pmbus_ident_and_store_lock (.clk(clk), .rst_n(rst_n), .txn_start(txn_start),
    .txn_cmd(txn_cmd), .txn_write(txn_write), .txn_end(txn_end),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
    .lock_wr_valid(lock_wr_valid), .lock_wr_data(lock_wr_data), .restore(restore),
    .nvm_store_lock(nvm_store_lock), .wp_blocks_store(wp), .key_blocks_store(key),
    .cmd_ack(cmd_ack), .rd_byte(rd_byte), .rd_valid(rd_valid),
    .store_lock_bit(store_lock_bit), .store_cmd_writable(store_cmd_writable),
    .cml_fault(cml_fault));

  pmbus_host_model u_pmbus_host_model (.clk(clk), .cmd_ack(cmd_ack), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .txn_start(txn_start), .txn_cmd(txn_cmd), .txn_write(txn_write),
    .txn_end(txn_end), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 1000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic txn(input logic [7:0] c, input logic w, input int n);
    u_pmbus_host_model.xfer(c, w, n, ack, q);
  endtask

  // Both identities in full, plus one pad byte past the string
  task automatic read_ids;
    txn(`CMD_IDENT_WORD, 1'b0, 2);
    check(ack, 8'h01);
    check(q[0], WORD[7:0]);
    check(q[1], WORD[15:8]);
    txn(`CMD_IDENT_STRING, 1'b0, 8);
    check(ack, 8'h01);
    check(q[0], 8'h06);
    for (int i = 1; i < 7; i++) check(q[i], STR[8*i-8 +: 8]);
    check(q[7], `IDENT_PAD_BYTE);
  endtask

  // Drops the pulses, lets lock and then writable settle, compares
  task automatic lock_chk(input logic lk, input logic wt);
    @(posedge clk);
    #5 lock_wr_valid = 1'b0;
    restore = 1'b0;
    @(posedge clk);
    #5 check(store_lock_bit, lk);
    check(store_cmd_writable, wt);
  endtask

  initial begin
    {rst_n, lock_wr_valid, lock_wr_data, restore, wp, key} = '0;
    nvm_store_lock = 1'b1;
    {errors, comparisons, cycles} = '0;
    repeat (2) @(posedge clk);
    #5 rst_n = 1'b1;
    lock_chk(1'b1, 1'b0);
    read_ids();
    nvm_store_lock = 1'b0;
    restore = 1'b1;
    lock_chk(1'b0, 1'b1);
    wp = 1'b1;
    lock_chk(1'b0, 1'b0);
    wp = 1'b0;
    key = 1'b1;
    lock_chk(1'b0, 1'b0);
    key = 1'b0;
    lock_wr_valid = 1'b1;
    lock_wr_data = 1'b1;
    lock_chk(1'b1, 1'b0);
    lock_wr_valid = 1'b1;
    lock_wr_data = 1'b0;
    lock_chk(1'b0, 1'b1);
    nvm_store_lock = 1'b1;
    restore = 1'b1;
    lock_chk(1'b1, 1'b0);
    // Writes are taken like any other and leave no trace
    txn(`CMD_IDENT_WORD, 1'b1, 2);
    check(ack, 8'h01);
    check(cml_fault, 8'h00);
    txn(`CMD_IDENT_STRING, 1'b1, 7);
    check(ack, 8'h01);
    check(cml_fault, 8'h00);
    read_ids();
    // A neighbouring code is not ours
    txn(8'hFB, 1'b0, 1);
    check(ack, 8'h00);
    nvm_store_lock = 1'b0;
    rst_n = 1'b0;
    @(posedge clk);
    #5 rst_n = 1'b1;
    lock_chk(1'b0, 1'b1);
    read_ids();
    summarize();
  end
endmodule

`default_nettype wire
